// File: src/dbgmon_top.sv
`timescale 1ns/1ns
`default_nettype none

module dbgmon_top #(
  parameter int BAUD_DIV = dbgmon_pkg::BAUD_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire dbgmon_pkg::dbgmon_bus_req_s BUS_REQ,
  output logic [7:0] RD_DATA,
  input wire logic IRQ_PIN,
  input wire logic IRQ_TEST_HIGH_VOLTAGE,
  input wire logic [15:0] RESET_VECTOR,
  input wire logic [7:0] FLASH_TRIM_VALUE,
  input wire logic EMULATION_MODE,
  input wire logic BREAK_REQ,
  input wire logic BREAK_EXIT,
  input wire logic WAIT_ACTIVE,
  input wire logic MONITOR_SERIAL_PIN_IN,
  output logic MONITOR_SERIAL_PIN_OUT,
  output logic MONITOR_SERIAL_PIN_OE,
  output logic WATCHDOG_HOLD,
  output logic SOFTWARE_INTERRUPT_FETCH,
  output logic BREAK_STATE,
  output logic MONITOR_MODE,
  output logic INTERNAL_OSC_ENABLE,
  output logic EXTERNAL_CLOCK_SELECT,
  output logic [7:0] OSCILLATOR_TRIM_VALUE,
  output logic IRQ
);

  localparam int CW = $clog2(BAUD_DIV + 1);

  if (BAUD_DIV < 4) begin : g_bad_div
    $error("BAUD_DIV must be at least 4");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_f;

  assign pin_raw = {MONITOR_SERIAL_PIN_IN, IRQ_TEST_HIGH_VOLTAGE, IRQ_PIN};

  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_sync
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        sync1[gi] <= 1'b1;
        sync2[gi] <= 1'b1;
        sync3[gi] <= 1'b1;
        pin_f[gi] <= 1'b1;
      end else begin
        sync1[gi] <= pin_raw[gi];
        sync2[gi] <= sync1[gi];
        sync3[gi] <= sync2[gi];
        // A change counts only once two stages agree
        if (sync2[gi] == sync3[gi]) begin
          pin_f[gi] <= sync3[gi];
        end
      end
    end
  end

  logic irq_high;
  logic irq_tst;
  logic line_in;
  assign irq_high = pin_f[0];
  assign irq_tst = pin_f[1];
  assign line_in = pin_f[2];

  function automatic logic hit(input dbgmon_pkg::dbgmon_bus_req_s r, input logic [7:0] ofs);
    hit = r.addr == ofs;
  endfunction

  logic wr_aux;
  logic wr_bstat;
  logic wr_tx;
  logic wr_mask;
  logic rd_rx;
  logic rd_irq;
  assign wr_aux = BUS_REQ.wr && hit(BUS_REQ, dbgmon_pkg::OFS_BRK_AUX);
  assign wr_bstat = BUS_REQ.wr && hit(BUS_REQ, dbgmon_pkg::OFS_BRK_STAT);
  assign wr_tx = BUS_REQ.wr && hit(BUS_REQ, dbgmon_pkg::OFS_TX_DATA);
  assign wr_mask = BUS_REQ.wr && hit(BUS_REQ, dbgmon_pkg::OFS_IRQ_MASK);
  assign rd_rx = BUS_REQ.rd && hit(BUS_REQ, dbgmon_pkg::OFS_RX_DATA);
  assign rd_irq = BUS_REQ.rd && hit(BUS_REQ, dbgmon_pkg::OFS_IRQ_STAT);

  // ----------------------------------------------------------------
  // Monitor entry decision
  // ----------------------------------------------------------------
  logic [2:0] settle;
  logic decided;
  dbgmon_pkg::dbgmon_mon_cfg_s cfg;
  logic vec_erased;
  assign vec_erased = RESET_VECTOR == dbgmon_pkg::VECTOR_ERASED;

  // Waits for the synchronisers to fill so the pin levels are real
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      settle <= 3'h0;
      decided <= 1'b0;
      cfg <= '0;
    end else if (!decided) begin
      if (settle == 3'(dbgmon_pkg::SETTLE_CYCLES)) begin
        decided <= 1'b1;
        if (irq_tst) begin
          cfg <= '{active: 1'b1, int_osc: 1'b0, trim_ok: 1'b0};
        end else if (vec_erased && irq_high) begin
          cfg <= '{active: 1'b1, int_osc: 1'b0, trim_ok: 1'b0};
        end else if (vec_erased) begin
          cfg.active <= 1'b1;
          cfg.int_osc <= 1'b1;
          cfg.trim_ok <= FLASH_TRIM_VALUE != dbgmon_pkg::TRIM_ERASED;
        end else begin
          cfg <= '0;
        end
      end else begin
        settle <= settle + 3'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MONITOR_MODE <= 1'b0;
      INTERNAL_OSC_ENABLE <= 1'b0;
      EXTERNAL_CLOCK_SELECT <= 1'b0;
      OSCILLATOR_TRIM_VALUE <= dbgmon_pkg::RST_TRIM;
    end else begin
      MONITOR_MODE <= cfg.active;
      INTERNAL_OSC_ENABLE <= cfg.int_osc;
      EXTERNAL_CLOCK_SELECT <= cfg.active && !cfg.int_osc;
      if (decided && cfg.trim_ok) begin
        OSCILLATOR_TRIM_VALUE <= FLASH_TRIM_VALUE;
      end
    end
  end

  // Raising the pin mid-session drops the oscillator option, so stop talking
  logic link_lost;
  logic link_ok;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      link_lost <= 1'b0;
    end else if (decided && cfg.int_osc && irq_high) begin
      link_lost <= 1'b1;
    end
  end
  assign link_ok = decided && cfg.active && !link_lost;

  // ----------------------------------------------------------------
  // Break state
  // ----------------------------------------------------------------
  logic wdog_suspend;
  logic wake_flag;
  logic brk_entry;
  assign brk_entry = BREAK_REQ && !BREAK_STATE;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wdog_suspend <= dbgmon_pkg::RST_BRK_AUX[dbgmon_pkg::BIT_WDOG_SUSPEND];
    end else if (wr_aux) begin
      wdog_suspend <= BUS_REQ.wdata[dbgmon_pkg::BIT_WDOG_SUSPEND];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BREAK_STATE <= 1'b0;
      SOFTWARE_INTERRUPT_FETCH <= 1'b0;
      WATCHDOG_HOLD <= 1'b0;
    end else begin
      SOFTWARE_INTERRUPT_FETCH <= brk_entry;
      if (brk_entry) begin
        BREAK_STATE <= 1'b1;
      end else if (BREAK_EXIT) begin
        BREAK_STATE <= 1'b0;
      end
      WATCHDOG_HOLD <= wdog_suspend && (brk_entry || (BREAK_STATE && !BREAK_EXIT));
    end
  end

  // Entry in emulation mode decides the flag; software clears it by writing 0, entry wins
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wake_flag <= 1'b0;
    end else if (brk_entry && EMULATION_MODE) begin
      wake_flag <= WAIT_ACTIVE;
    end else if (wr_bstat && !BUS_REQ.wdata[dbgmon_pkg::BIT_BRK_WAKE]) begin
      wake_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Monitor serial line
  // ----------------------------------------------------------------
  dbgmon_pkg::dbgmon_rx_e rx_st;
  dbgmon_pkg::dbgmon_tx_e tx_st;
  logic [CW-1:0] rx_cnt;
  logic [CW-1:0] tx_cnt;
  logic [2:0] rx_bit;
  logic [2:0] tx_bit;
  logic [7:0] rx_shift;
  logic [7:0] rx_data;
  logic rx_full;
  logic [7:0] tx_shift;
  logic rx_done;
  logic frame_err;
  logic tx_done;
  logic rx_tick;
  logic tx_tick;
  assign rx_tick = rx_cnt == CW'(BAUD_DIV - 1);
  assign tx_tick = tx_cnt == CW'(BAUD_DIV - 1);

  // Receiver is blind while transmitting: the shared line echoes our own bits
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_st <= dbgmon_pkg::RX_IDLE;
      rx_cnt <= '0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      frame_err <= 1'b0;
      rx_cnt <= rx_tick ? '0 : rx_cnt + CW'(1);
      case (rx_st)
        dbgmon_pkg::RX_IDLE: begin
          rx_cnt <= CW'(BAUD_DIV / 2);
          if (link_ok && !line_in && tx_st == dbgmon_pkg::TX_IDLE) begin
            rx_st <= dbgmon_pkg::RX_START;
          end
        end
        dbgmon_pkg::RX_START: begin
          if (rx_tick) begin
            rx_st <= line_in ? dbgmon_pkg::RX_IDLE : dbgmon_pkg::RX_DATA;
            rx_bit <= 3'h0;
          end
        end
        dbgmon_pkg::RX_DATA: begin
          if (rx_tick) begin
            rx_shift <= {line_in, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_st <= dbgmon_pkg::RX_STOP;
            end
          end
        end
        dbgmon_pkg::RX_STOP: begin
          if (rx_tick) begin
            rx_st <= dbgmon_pkg::RX_IDLE;
            rx_done <= line_in;
            frame_err <= !line_in;
          end
        end
        default: rx_st <= dbgmon_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_data <= 8'h00;
      rx_full <= 1'b0;
    end else if (rx_done) begin
      rx_data <= rx_shift;
      rx_full <= 1'b1;
    end else if (rd_rx) begin
      rx_full <= 1'b0;
    end
  end

  // Transmit by pulling low only; a 1 releases the line to the pull-up
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_st <= dbgmon_pkg::TX_IDLE;
      tx_cnt <= '0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      tx_done <= 1'b0;
      MONITOR_SERIAL_PIN_OE <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      tx_cnt <= tx_tick ? '0 : tx_cnt + CW'(1);
      case (tx_st)
        dbgmon_pkg::TX_IDLE: begin
          tx_cnt <= '0;
          MONITOR_SERIAL_PIN_OE <= 1'b0;
          if (wr_tx && link_ok && rx_st == dbgmon_pkg::RX_IDLE) begin
            tx_shift <= BUS_REQ.wdata;
            tx_bit <= 3'h0;
            MONITOR_SERIAL_PIN_OE <= 1'b1;
            tx_st <= dbgmon_pkg::TX_SHIFT;
          end
        end
        dbgmon_pkg::TX_SHIFT: begin
          if (tx_tick) begin
            MONITOR_SERIAL_PIN_OE <= !tx_shift[0];
            tx_shift <= {1'b1, tx_shift[7:1]};
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == 3'h7) begin
              tx_st <= dbgmon_pkg::TX_STOP;
            end
          end
        end
        dbgmon_pkg::TX_STOP: begin
          // Bit count wrapped to 0 on entry: first tick ends d7, second ends the stop bit
          if (tx_tick) begin
            MONITOR_SERIAL_PIN_OE <= 1'b0;
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == 3'h1) begin
              tx_st <= dbgmon_pkg::TX_IDLE;
              tx_done <= 1'b1;
            end
          end
        end
        default: tx_st <= dbgmon_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MONITOR_SERIAL_PIN_OUT <= 1'b0;
    end else begin
      MONITOR_SERIAL_PIN_OUT <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and read port
  // ----------------------------------------------------------------
  logic [dbgmon_pkg::IRQ_BITS-1:0] irq_stat;
  logic [dbgmon_pkg::IRQ_BITS-1:0] irq_mask;
  logic [dbgmon_pkg::IRQ_BITS-1:0] irq_evt;
  logic lost_q;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lost_q <= 1'b0;
    end else begin
      lost_q <= link_lost;
    end
  end
  assign irq_evt = {link_lost && !lost_q, brk_entry, frame_err, tx_done, rx_done};

  // A read clears status, but an event in the same cycle stays set
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (rd_irq ? '0 : irq_stat) | irq_evt;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_mask <= dbgmon_pkg::RST_IRQ_MASK[dbgmon_pkg::IRQ_BITS-1:0];
      IRQ <= 1'b0;
    end else begin
      if (wr_mask) begin
        irq_mask <= BUS_REQ.wdata[dbgmon_pkg::IRQ_BITS-1:0];
      end
      IRQ <= |((irq_stat | irq_evt) & irq_mask);
    end
  end

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (BUS_REQ.addr)
      dbgmon_pkg::OFS_BRK_AUX: rd_mux[dbgmon_pkg::BIT_WDOG_SUSPEND] = wdog_suspend;
      dbgmon_pkg::OFS_BRK_STAT: rd_mux[dbgmon_pkg::BIT_BRK_WAKE] = wake_flag;
      dbgmon_pkg::OFS_MON_STAT: begin
        rd_mux[dbgmon_pkg::BIT_MON_ACTIVE] = cfg.active;
        rd_mux[dbgmon_pkg::BIT_MON_INT_OSC] = cfg.int_osc;
        rd_mux[dbgmon_pkg::BIT_MON_TRIM] = cfg.trim_ok;
        rd_mux[dbgmon_pkg::BIT_MON_TX_BUSY] = tx_st != dbgmon_pkg::TX_IDLE;
        rd_mux[dbgmon_pkg::BIT_MON_RX_FULL] = rx_full;
        rd_mux[dbgmon_pkg::BIT_MON_LOST] = link_lost;
      end
      dbgmon_pkg::OFS_RX_DATA: rd_mux = rx_data;
      dbgmon_pkg::OFS_IRQ_STAT: rd_mux[dbgmon_pkg::IRQ_BITS-1:0] = irq_stat;
      dbgmon_pkg::OFS_IRQ_MASK: rd_mux[dbgmon_pkg::IRQ_BITS-1:0] = irq_mask;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA <= 8'h00;
    end else begin
      RD_DATA <= BUS_REQ.rd ? rd_mux : 8'h00;
    end
  end

endmodule

`default_nettype wire

// File: src/dbgmon_pkg.sv
package dbgmon_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_BRK_AUX = 8'h00;
  localparam logic [7:0] OFS_BRK_STAT = 8'h01;
  localparam logic [7:0] OFS_MON_STAT = 8'h02;
  localparam logic [7:0] OFS_RX_DATA = 8'h03;
  localparam logic [7:0] OFS_TX_DATA = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h05;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h06;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_WDOG_SUSPEND = 0;
  localparam int BIT_BRK_WAKE = 1;
  localparam int BIT_MON_ACTIVE = 0;
  localparam int BIT_MON_INT_OSC = 1;
  localparam int BIT_MON_TRIM = 2;
  localparam int BIT_MON_TX_BUSY = 3;
  localparam int BIT_MON_RX_FULL = 4;
  localparam int BIT_MON_LOST = 5;
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_FRAME_ERR = 2;
  localparam int IRQ_BRK_ENTRY = 3;
  localparam int IRQ_LINK_LOST = 4;
  localparam int IRQ_BITS = 5;
  localparam logic [7:0] RST_BRK_AUX = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h80;

  // ----------------------------------------------------------------
  // Monitor entry and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] VECTOR_ERASED = 16'hffff;
  localparam logic [7:0] TRIM_ERASED = 8'hff;
  localparam longint CLK_HZ = 250000000;
  localparam longint MON_BAUD = 9600;
  localparam int BAUD_CYCLES = int'(CLK_HZ / MON_BAUD);
  localparam int SETTLE_CYCLES = 4;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dbgmon_bus_req_s;

  typedef struct packed {
    logic active;
    logic int_osc;
    logic trim_ok;
  } dbgmon_mon_cfg_s;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } dbgmon_rx_e;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_STOP = 3'b100
  } dbgmon_tx_e;

endpackage

// File: testbench/dbgmon_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module dbgmon_top_monitor #(
  parameter int BAUD_DIV = 8
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire dbgmon_pkg::dbgmon_bus_req_s BUS_REQ,
  input wire logic [7:0] RD_DATA,
  input wire logic IRQ_PIN,
  input wire logic IRQ_TEST_HIGH_VOLTAGE,
  input wire logic [15:0] RESET_VECTOR,
  input wire logic [7:0] FLASH_TRIM_VALUE,
  input wire logic EMULATION_MODE,
  input wire logic BREAK_REQ,
  input wire logic BREAK_EXIT,
  input wire logic WAIT_ACTIVE,
  input wire logic MONITOR_SERIAL_PIN_IN,
  input wire logic MONITOR_SERIAL_PIN_OUT,
  input wire logic MONITOR_SERIAL_PIN_OE,
  input wire logic WATCHDOG_HOLD,
  input wire logic SOFTWARE_INTERRUPT_FETCH,
  input wire logic BREAK_STATE,
  input wire logic MONITOR_MODE,
  input wire logic INTERNAL_OSC_ENABLE,
  input wire logic EXTERNAL_CLOCK_SELECT,
  input wire logic [7:0] OSCILLATOR_TRIM_VALUE,
  input wire logic IRQ
);
  // ----------------------------------------------------------------
  // Cycles since reset; the entry decision lands by edge 6
  // ----------------------------------------------------------------
  logic [3:0] age;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      age <= 4'h0;
    end else if (age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_brk_take;
    BREAK_REQ && !BREAK_STATE |=> BREAK_STATE && SOFTWARE_INTERRUPT_FETCH;
  endproperty
  a_brk_take: assert property (p_brk_take) else $error("break not taken");
  property p_fetch_pulse;
    SOFTWARE_INTERRUPT_FETCH |-> $rose(BREAK_STATE) ##1 !SOFTWARE_INTERRUPT_FETCH;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch pulse bad");
  property p_hold_in_break;
    WATCHDOG_HOLD |-> BREAK_STATE;
  endproperty
  a_hold_in_break: assert property (p_hold_in_break) else $error("hold outside break");
  property p_exit;
    BREAK_STATE && BREAK_EXIT |=> !BREAK_STATE && !WATCHDOG_HOLD;
  endproperty
  a_exit: assert property (p_exit) else $error("break exit bad");
  property p_pin_release;
    !MONITOR_SERIAL_PIN_OUT;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin driven high");
  property p_oe_mon;
    MONITOR_SERIAL_PIN_OE |-> MONITOR_MODE;
  endproperty
  a_oe_mon: assert property (p_oe_mon) else $error("serial outside monitor");
  property p_latched;
    age >= 4'h7 |-> $stable(MONITOR_MODE) && $stable(INTERNAL_OSC_ENABLE)
      && $stable(EXTERNAL_CLOCK_SELECT) && $stable(OSCILLATOR_TRIM_VALUE);
  endproperty
  a_latched: assert property (p_latched) else $error("entry decision moved");
  property p_osc_excl;
    INTERNAL_OSC_ENABLE |-> MONITOR_MODE && !EXTERNAL_CLOCK_SELECT;
  endproperty
  a_osc_excl: assert property (p_osc_excl) else $error("clock choice bad");
  property p_trim_ext;
    age >= 4'h7 && !INTERNAL_OSC_ENABLE |-> OSCILLATOR_TRIM_VALUE == dbgmon_pkg::RST_TRIM;
  endproperty
  a_trim_ext: assert property (p_trim_ext) else $error("trim without int osc");
  property p_stat_rd;
    BUS_REQ.rd && BUS_REQ.addr == dbgmon_pkg::OFS_BRK_STAT |=> (RD_DATA & 8'hfd) == 8'h00;
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("break status bits bad");
  c_brk: cover property (BREAK_STATE && WATCHDOG_HOLD);
  c_tx: cover property ($rose(MONITOR_SERIAL_PIN_OE));
  c_int: cover property (INTERNAL_OSC_ENABLE);
endmodule

bind dbgmon_top dbgmon_top_monitor #(.BAUD_DIV(BAUD_DIV)) u_mon (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .BUS_REQ(BUS_REQ), .RD_DATA(RD_DATA),
  .IRQ_PIN(IRQ_PIN), .IRQ_TEST_HIGH_VOLTAGE(IRQ_TEST_HIGH_VOLTAGE),
  .RESET_VECTOR(RESET_VECTOR), .FLASH_TRIM_VALUE(FLASH_TRIM_VALUE),
  .EMULATION_MODE(EMULATION_MODE), .BREAK_REQ(BREAK_REQ), .BREAK_EXIT(BREAK_EXIT),
  .WAIT_ACTIVE(WAIT_ACTIVE), .MONITOR_SERIAL_PIN_IN(MONITOR_SERIAL_PIN_IN),
  .MONITOR_SERIAL_PIN_OUT(MONITOR_SERIAL_PIN_OUT),
  .MONITOR_SERIAL_PIN_OE(MONITOR_SERIAL_PIN_OE), .WATCHDOG_HOLD(WATCHDOG_HOLD),
  .SOFTWARE_INTERRUPT_FETCH(SOFTWARE_INTERRUPT_FETCH), .BREAK_STATE(BREAK_STATE),
  .MONITOR_MODE(MONITOR_MODE), .INTERNAL_OSC_ENABLE(INTERNAL_OSC_ENABLE),
  .EXTERNAL_CLOCK_SELECT(EXTERNAL_CLOCK_SELECT),
  .OSCILLATOR_TRIM_VALUE(OSCILLATOR_TRIM_VALUE), .IRQ(IRQ)
);
`default_nettype wire

// File: testbench/dbgmon_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module dbgmon_host_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk,
  input wire logic line,
  output logic pull_low
);
  // ----------------------------------------------------------------
  // Host side of the shared line: only ever pulls low or lets go
  // ----------------------------------------------------------------
  initial pull_low = 1'b0;
  task automatic send(input logic [7:0] b);
    int i;
    @(posedge clk) pull_low <= 1'b1;
    repeat (BIT_CYC) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      pull_low <= ~b[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    pull_low <= 1'b0;
    repeat (BIT_CYC) @(posedge clk);
  endtask
  // Gives up after a bounded wait, leaving the start flag clear
  task automatic recv(output logic [7:0] b, output logic stop, output logic seen);
    int i;
    seen = 1'b0;
    b = 8'h00;
    stop = 1'b0;
    for (i = 0; i < 40 * BIT_CYC && !seen; i++) begin
      @(posedge clk);
      seen = !line;
    end
    if (seen) begin
      repeat (BIT_CYC / 2) @(posedge clk);
      for (i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        b[i] = line;
      end
      repeat (BIT_CYC) @(posedge clk);
      stop = line;
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/dbgmon_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dbgmon_top_bench;
  localparam int BIT = 8;
  logic clk = 1'b0, rst_n = 1'b0, irq_pin = 1'b0, tv = 1'b0, emu = 1'b0;
  logic brk_req = 1'b0, brk_exit = 1'b0, wait_act = 1'b0;
  logic [15:0] vec = 16'hffff;
  logic [7:0] ftrim = 8'h5a;
  dbgmon_pkg::dbgmon_bus_req_s req = '0;
  logic [7:0] rd_data, trim, v;
  logic oe, pin_out, hold, fetch, brk, mon, int_osc, ext_clk, irq, host_pull, line, stop, seen;
  int error_cnt = 0, tests_run = 0;
  // Pull-up wins unless either side pulls low
  assign line = !(oe | host_pull);
  dbgmon_top #(.BAUD_DIV(BIT)) dut (
    .CORE_CLK(clk), .RST_N(rst_n), .BUS_REQ(req), .RD_DATA(rd_data), .IRQ_PIN(irq_pin),
    .IRQ_TEST_HIGH_VOLTAGE(tv), .RESET_VECTOR(vec), .FLASH_TRIM_VALUE(ftrim),
    .EMULATION_MODE(emu), .BREAK_REQ(brk_req), .BREAK_EXIT(brk_exit),
    .WAIT_ACTIVE(wait_act), .MONITOR_SERIAL_PIN_IN(line), .MONITOR_SERIAL_PIN_OUT(pin_out),
    .MONITOR_SERIAL_PIN_OE(oe), .WATCHDOG_HOLD(hold), .SOFTWARE_INTERRUPT_FETCH(fetch),
    .BREAK_STATE(brk), .MONITOR_MODE(mon), .INTERNAL_OSC_ENABLE(int_osc),
    .EXTERNAL_CLOCK_SELECT(ext_clk), .OSCILLATOR_TRIM_VALUE(trim), .IRQ(irq)
  );
  dbgmon_host_model #(.BIT_CYC(BIT)) host (.clk(clk), .line(line), .pull_low(host_pull));
  initial begin
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= '0;
    #1 d = rd_data;
  endtask
  task automatic boot(input logic p, input logic t, input logic [15:0] vc);
    @(posedge clk) rst_n <= 1'b0;
    irq_pin <= p;
    tv <= t;
    vec <= vc;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic brk_run(input logic w, input logic e, input logic eh, input logic [7:0] ef);
    @(posedge clk) brk_req <= 1'b1;
    wait_act <= w;
    emu <= e;
    @(posedge clk) brk_req <= 1'b0;
    #1 chk("break_state", 8'h01, {7'h0, brk});
    chk("sw_fetch", 8'h01, {7'h0, fetch});
    chk("wdog_hold", {7'h0, eh}, {7'h0, hold});
    @(posedge clk) #1 chk("sw_fetch_end", 8'h00, {7'h0, fetch});
    rd(dbgmon_pkg::OFS_BRK_STAT, v);
    chk("wake_flag", ef, v);
    @(posedge clk) brk_exit <= 1'b1;
    @(posedge clk) brk_exit <= 1'b0;
    #1 chk("break_left", 8'h00, {6'h0, brk, hold});
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  logic [15:0] cv [5] = '{16'h1234, 16'h1234, 16'hffff, 16'hffff, 16'hffff};
  logic [1:0] cp [5] = '{2'b00, 2'b11, 2'b10, 2'b00, 2'b00};
  logic [10:0] ce [5] = '{11'h080, 11'h580, 11'h580, 11'h680, 11'h65a};
  logic [7:0] ct [5] = '{8'h5a, 8'h5a, 8'h5a, 8'hff, 8'h5a};
  initial begin
    repeat (4) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      ftrim <= ct[i];
      boot(cp[i][1], cp[i][0], cv[i]);
      chk("mode", 8'(ce[i][10:8]), 8'({mon, int_osc, ext_clk}));
      chk("trim", ce[i][7:0], trim);
      vec <= ~cv[i];
      repeat (4) @(posedge clk);
      chk("mode_held", 8'(ce[i][10:8]), 8'({mon, int_osc, ext_clk}));
      vec <= cv[i];
    end
    rd(dbgmon_pkg::OFS_BRK_AUX, v);
    chk("aux_reset", dbgmon_pkg::RST_BRK_AUX, v);
    rd(8'h07, v);
    chk("unmapped", 8'h00, v);
    wr(dbgmon_pkg::OFS_BRK_AUX, 8'h01);
    rd(dbgmon_pkg::OFS_BRK_AUX, v);
    chk("aux_rw", 8'h01, v);
    brk_run(1'b1, 1'b1, 1'b1, 8'h02);
    chk("irq_masked", 8'h00, {7'h0, irq});
    rd(dbgmon_pkg::OFS_IRQ_STAT, v);
    chk("irq_stat", 8'h08, v);
    wr(dbgmon_pkg::OFS_BRK_STAT, 8'h00);
    wr(dbgmon_pkg::OFS_BRK_AUX, 8'h00);
    wr(dbgmon_pkg::OFS_IRQ_MASK, 8'h08);
    brk_run(1'b0, 1'b1, 1'b0, 8'h00);
    chk("irq_up", 8'h01, {7'h0, irq});
    rd(dbgmon_pkg::OFS_IRQ_STAT, v);
    chk("irq_stat_rd", 8'h08, v);
    repeat (2) @(posedge clk);
    #1 chk("irq_down", 8'h00, {7'h0, irq});
    brk_run(1'b1, 1'b0, 1'b0, 8'h00);
    fork
      host.recv(v, stop, seen);
      wr(dbgmon_pkg::OFS_TX_DATA, 8'ha5);
    join
    chk("tx_byte", 8'ha5, v);
    chk("tx_stop", 8'h03, {6'h0, seen, stop});
    repeat (3 * BIT) @(posedge clk);
    host.send(8'h3c);
    repeat (6) @(posedge clk);
    rd(dbgmon_pkg::OFS_MON_STAT, v);
    chk("mon_stat", 8'h17, v);
    rd(dbgmon_pkg::OFS_RX_DATA, v);
    chk("rx_byte", 8'h3c, v);
    @(posedge clk) irq_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd(dbgmon_pkg::OFS_MON_STAT, v);
    chk("link_lost", 8'h20, v & 8'h20);
    wr(dbgmon_pkg::OFS_TX_DATA, 8'h11);
    repeat (2) @(posedge clk);
    #1 chk("tx_blocked", 8'h00, {7'h0, oe});
    conclude();
  end
endmodule
`default_nettype wire
